// *** design/occ_cfg.svh ***
// Command codes, field positions, reset values and timing counts for the
// OLED command tail. Definitions only; included by the occ_ctrl module.
`ifndef OCC_CFG_SVH
`define OCC_CFG_SVH
`define OCC_CMD_PERIOD 8'hD9
`define OCC_CMD_LAYOUT 8'hDA
`define OCC_CMD_DESEL 8'hDB
`define OCC_CMD_RMW 8'hE0
`define OCC_CMD_END 8'hEE
`define OCC_CMD_NOP 8'hE3
`define OCC_CMD_DISP 7'b1010_111
`define OCC_CMD_PAGE 5'b1011_0
`define OCC_CMD_COL_LO 4'h0
`define OCC_CMD_COL_HI 4'h1
`define OCC_PERIOD_POR 8'h22
`define OCC_LAYOUT_POR 1'b1
`define OCC_DESEL_POR 8'h35
`define OCC_DESEL_SAT 8'h40
`define OCC_COL_POR 8'h00
`define OCC_LAYOUT_BIT 4
`define OCC_BUSY_BIT 7
`define OCC_OFF_BIT 6
`define OCC_BUSY_NS 200
`define OCC_CLK_NS 100
`define OCC_BUSY_CYC ((`OCC_BUSY_NS + `OCC_CLK_NS - 1) / `OCC_CLK_NS)
`define OCC_FIFO_DEPTH 8
`endif

// *** design/occ_ctrl.sv ***
// Command decoder and display RAM access for the OLED controller tail.
// Assumes host accesses arrive as synchronous one-cycle strobes on clk_in.
// Summary of operation
// - D9H then a data byte sets discharge high nibble, precharge low.
// - Precharge lasts low-nibble ticks, 1 to 15; reset value 2.
// - Discharge lasts high-nibble ticks, 1 to 15; reset value 2.
// - DAH then 02H or 12H selects the common pad layout.
// - Layout bit 4 low sequential, high alternative; reset alternative.
// - DBH then any byte stores the common deselect level code.
// - Ratio 0.430 plus code times 0.006415 below 40H, else one.
// - E0H saves column, enters read-modify-write; reads hold column.
// - EEH leaves read-modify-write and restores the saved column.
// - Data write stores byte at page and column, column advances.
// - Status read: bit 7 busy, bits 2..0 zero; commands wait out busy.
// - Status bit 6 is high while the display is off.
// - Data read returns RAM byte; column advances except in RMW or on a dummy read.
// - First data read after a column set is a dummy read.
// - No display data readback while the serial interface is selected.
`timescale 1ns/1ps
`include "occ_cfg.svh"
module occ_ctrl
   import occ_pkg::*;
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic acc_valid_in,
   output logic acc_ready_out,
   input wire logic acc_cds_in,
   input wire logic acc_rd_in,
   input wire logic [7:0] acc_data_in,
   input wire logic serial_sel_in,
   output logic [7:0] rd_data_out,
   output logic rd_valid_out,
   output logic [3:0] precharge_ticks_out,
   output logic [3:0] discharge_ticks_out,
   output logic layout_alt_out,
   output logic [7:0] deselect_code_out,
   output logic deselect_full_out,
   output logic display_on_out,
   output logic rmw_active_out,
   output logic [2:0] page_out,
   output logic [7:0] column_out
);
   // ------------------------------------------------------------------
   // Access queue
   // ------------------------------------------------------------------
   occ_acc_t q_in;
   occ_acc_t q_out;
   logic q_valid;
   logic q_ready;
   assign q_in = '{cds: acc_cds_in, rd: acc_rd_in, data: acc_data_in};
   occ_fifo #(.WIDTH(10), .DEPTH(`OCC_FIFO_DEPTH)) u_fifo (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .in_valid_in(acc_valid_in),
      .in_ready_out(acc_ready_out),
      .in_data_in(q_in),
      .out_valid_out(q_valid),
      .out_ready_in(q_ready),
      .out_data_out(q_out)
   );

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   occ_state_t state;
   occ_state_t next_state;
   logic [7:0] ram [8*256];
   logic [7:0] period;
   logic layout_alt;
   logic [7:0] desel;
   logic disp_on;
   logic rmw;
   logic [7:0] col_save;
   logic [7:0] col;
   logic [2:0] page;
   logic dummy_due;
   logic [7:0] latch;
   logic [1:0] busy_cnt;
   logic [7:0] rd_data;
   logic rd_valid;

   // Keep a phase nibble when the new one is zero
   function automatic logic [3:0] keep_nz(input logic [3:0] nw,
                                          input logic [3:0] old);
      keep_nz = (nw == 4'h0) ? old : nw;
   endfunction : keep_nz

   // ------------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------------
   wire busy = (busy_cnt != 2'h0);
   // A status read is always served; commands and data wait out busy
   wire is_stat = q_valid && !q_out.cds && q_out.rd;
   assign q_ready = is_stat || !busy;
   wire take = q_valid && q_ready;
   wire [7:0] b = q_out.data;
   wire cmd_wr = take && !q_out.cds && !q_out.rd;
   wire dat_wr = take && q_out.cds && !q_out.rd;
   wire dat_rd = take && q_out.cds && q_out.rd;
   wire stat_rd = take && is_stat;
   wire idle_cmd = cmd_wr && (state == OCC_IDLE);
   wire c_rmw = idle_cmd && (b == `OCC_CMD_RMW);
   wire c_end = idle_cmd && (b == `OCC_CMD_END);
   wire c_disp = idle_cmd && (b[7:1] == `OCC_CMD_DISP);
   wire c_page = idle_cmd && (b[7:3] == `OCC_CMD_PAGE);
   wire c_col_lo = idle_cmd && (b[7:4] == `OCC_CMD_COL_LO);
   wire c_col_hi = idle_cmd && (b[7:4] == `OCC_CMD_COL_HI);
   wire arg = cmd_wr && (state != OCC_IDLE);
   wire [10:0] addr = {page, col};
   wire rd_ok = dat_rd && !serial_sel_in;
   // First read after a column set is a dummy
   wire rd_real = rd_ok && !dummy_due;
   wire [7:0] status = {busy, !disp_on, 6'h00} & 8'hC0;

   // Next decoder state: two-byte commands wait for their argument
   always_comb begin
      next_state = state;
      if (cmd_wr) begin
         unique case (state)
            OCC_IDLE: begin
               if (b == `OCC_CMD_PERIOD) next_state = OCC_ARG_PERIOD;
               else if (b == `OCC_CMD_LAYOUT) next_state = OCC_ARG_LAYOUT;
               else if (b == `OCC_CMD_DESEL) next_state = OCC_ARG_DESEL;
            end
            OCC_ARG_PERIOD: next_state = OCC_IDLE;
            OCC_ARG_LAYOUT: next_state = OCC_IDLE;
            OCC_ARG_DESEL: next_state = OCC_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   // Decoder state and settings
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state <= OCC_IDLE;
         period <= `OCC_PERIOD_POR;
         layout_alt <= `OCC_LAYOUT_POR;
         desel <= `OCC_DESEL_POR;
         disp_on <= 1'b0;
      end else begin
         state <= next_state;
         if (arg && state == OCC_ARG_PERIOD)
            period <= {keep_nz(b[7:4], period[7:4]),
                       keep_nz(b[3:0], period[3:0])};
         if (arg && state == OCC_ARG_LAYOUT)
            layout_alt <= b[`OCC_LAYOUT_BIT];
         if (arg && state == OCC_ARG_DESEL) desel <= b;
         if (c_disp) disp_on <= b[0];
      end
   end

   // Address pointers and read-modify-write bookkeeping
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         col <= `OCC_COL_POR;
         page <= 3'h0;
         rmw <= 1'b0;
         col_save <= `OCC_COL_POR;
         dummy_due <= 1'b1;
      end else begin
         if (c_page) page <= b[2:0];
         if (c_col_lo) col <= {col[7:4], b[3:0]};
         if (c_col_hi) col <= {b[3:0], col[3:0]};
         if (c_rmw) begin
            rmw <= 1'b1;
            col_save <= col;
         end
         if (c_end && rmw) begin
            rmw <= 1'b0;
            col <= col_save;
         end
         if (dat_wr) col <= col + 8'h01;
         if (rd_real && !rmw) col <= col + 8'h01;
         if (c_col_lo || c_col_hi || (c_end && rmw)) dummy_due <= 1'b1;
         else if (rd_ok) dummy_due <= 1'b0;
      end
   end

   // Busy window after each command or data access
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         busy_cnt <= 2'(`OCC_BUSY_CYC);
      end else if (take && !is_stat) begin
         busy_cnt <= 2'(`OCC_BUSY_CYC);
      end else if (busy) begin
         busy_cnt <= busy_cnt - 2'h1;
      end
   end

   // Read answers; a dummy read hands back the stale latch
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
         latch <= 8'h00;
      end else begin
         rd_valid <= stat_rd || rd_ok;
         if (stat_rd) rd_data <= status;
         else if (rd_ok) rd_data <= dummy_due ? latch : ram[addr];
         if (rd_ok) latch <= ram[addr];
      end
   end

   // Display RAM; no reset, panel contents are undefined at power-up
   always_ff @(posedge clk_in) begin
      // Store byte at page and column
      if (dat_wr) ram[addr] <= b;
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   // Precharge nibble out
   assign precharge_ticks_out = period[3:0];
   assign discharge_ticks_out = period[7:4];
   assign layout_alt_out = layout_alt;
   assign deselect_code_out = desel;
   // Codes from 40H saturate the ratio at one
   assign deselect_full_out = (desel >= `OCC_DESEL_SAT);
   // Status bit 6 inverts display state
   assign display_on_out = disp_on;
   assign rmw_active_out = rmw;
   assign page_out = page;
   assign column_out = col;
   assign rd_data_out = rd_data;
   assign rd_valid_out = rd_valid;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   period_nonzero_a: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      period[3:0] != 4'h0 && period[7:4] != 4'h0)
      else $error("period nibble became zero");
   period_load_a: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      arg && state == OCC_ARG_PERIOD && b[3:0] != 4'h0 && b[7:4] != 4'h0
      |=> period == $past(b))
      else $error("period byte not stored");
   layout_load_a: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      arg && state == OCC_ARG_LAYOUT |=> layout_alt == $past(b[4]))
      else $error("layout bit not stored");
   desel_load_a: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      arg && state == OCC_ARG_DESEL |=> desel == $past(b))
      else $error("deselect code not stored");
   rmw_restore_a: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      c_end && rmw && !dat_wr |=> col == $past(col_save) && !rmw)
      else $error("column not restored on end");
   rmw_hold_a: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      rmw && rd_ok && !dat_wr && !c_col_lo && !c_col_hi && !c_end
      |=> $stable(col))
      else $error("column moved on rmw read");
   write_inc_a: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      dat_wr |=> col == $past(col) + 8'h01)
      else $error("column did not advance on write");
   busy_block_a: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      busy |-> !cmd_wr && !dat_wr)
      else $error("command taken while busy");
   status_bits_a: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      stat_rd |=> rd_valid && rd_data[6] == !$past(disp_on)
      && rd_data[2:0] == 3'h0)
      else $error("status byte wrong");
   serial_none_a: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      dat_rd && serial_sel_in |=> !rd_valid)
      else $error("readback in serial mode");
   // Further checks on arguments, pointers, the busy window, RAM stores and display state
   period_keep_a: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      arg && state == OCC_ARG_PERIOD && b[7:4] == 4'h0
      |=> period[7:4] == $past(period[7:4]))
      else $error("discharge nibble not kept");
   precharge_keep_a: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      arg && state == OCC_ARG_PERIOD && b[3:0] == 4'h0
      |=> period[3:0] == $past(period[3:0]))
      else $error("precharge nibble not kept");
   rmw_enter_a: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      c_rmw |=> rmw && col_save == $past(col))
      else $error("column not saved on rmw entry");
   read_inc_a: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      rd_real && !rmw |=> col == $past(col) + 8'h01)
      else $error("column did not advance on read");
   dummy_hold_a: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      rd_ok && dummy_due |=> $stable(col) && !dummy_due)
      else $error("dummy read moved column");
   dummy_arm_a: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      c_col_lo || c_col_hi |=> dummy_due)
      else $error("dummy read not armed");
   busy_flag_a: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      stat_rd |=> rd_data[7] == $past(busy))
      else $error("status busy bit wrong");
   busy_window_a: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      take && !is_stat |=> busy)
      else $error("no busy window after access");
   page_set_a: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      c_page |=> page == $past(b[2:0]))
      else $error("page not set");
   write_store_a: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      dat_wr |=> ram[$past(addr)] == $past(b))
      else $error("display byte not stored");
   display_set_a: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      c_disp |=> disp_on == $past(b[0]))
      else $error("display state not set");
endmodule : occ_ctrl

// *** design/occ_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module occ_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 8
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wptr;
   logic [AW-1:0] rptr;
   logic [AW:0] count;
   wire push = in_valid_in && in_ready_out;
   wire pop = out_valid_out && out_ready_in;
   // Honest flags straight from the count
   assign in_ready_out = (count < (AW+1)'(DEPTH));
   assign out_valid_out = (count != '0);
   assign out_data_out = mem[rptr];
   // Pointers and count
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wptr <= '0;
         rptr <= '0;
         count <= '0;
      end else begin
         if (push) wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
         if (pop) rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   // Storage has no reset; contents are qualified by count
   always_ff @(posedge clk_in) begin
      if (push) mem[wptr] <= in_data_in;
   end
endmodule : occ_fifo

// *** design/occ_pkg.sv ***
// Types shared by the OLED command tail modules.
// Assumes occ_cfg.svh sits on the include path.
package occ_pkg;
   // One host access: select line, read/write and the byte
   typedef struct packed {
      logic cds;
      logic rd;
      logic [7:0] data;
   } occ_acc_t;
   // Decoder state
   typedef enum logic [1:0] {
      OCC_IDLE = 2'b00,
      OCC_ARG_PERIOD = 2'b01,
      OCC_ARG_LAYOUT = 2'b10,
      OCC_ARG_DESEL = 2'b11
   } occ_state_t;
endpackage : occ_pkg

// *** testbench/occ_host_model.sv ***
// Host microprocessor model for the OLED command tail bench.
// Assumes one clock; the design takes a push when valid and ready are high.
`timescale 1ns/1ps
module occ_host_model (
   input wire logic clk_in,
   input wire logic acc_ready_in,
   input wire logic rd_valid_in,
   input wire logic [7:0] rd_data_in,
   output logic acc_valid_out,
   output logic acc_cds_out,
   output logic acc_rd_out,
   output logic [7:0] acc_data_out
);
   // Idle bus at time zero
   initial begin
      acc_valid_out = 1'b0;
      acc_cds_out = 1'b0;
      acc_rd_out = 1'b0;
      acc_data_out = 8'h00;
   end

   // -----------------------------------------------------------------
   // Access tasks
   // -----------------------------------------------------------------
   // One access held until taken; released lines show the inverse so a
   // stale byte is never mistaken for a live one.
   task automatic put(input logic cds, input logic rd, input logic [7:0] d);
      @(posedge clk_in);
      acc_valid_out <= 1'b1;
      acc_cds_out <= cds;
      acc_rd_out <= rd;
      acc_data_out <= d;
      do @(negedge clk_in); while (acc_ready_in !== 1'b1);
      @(posedge clk_in);
      acc_valid_out <= 1'b0;
      acc_cds_out <= ~cds;
      acc_rd_out <= ~rd;
      acc_data_out <= ~d;
   endtask : put

   // Read and wait a bounded time for the answer pulse
   task automatic get(input logic cds, output logic [7:0] d,
                      output logic ok);
      int n;
      put(cds, 1'b1, 8'h00);
      ok = 1'b0;
      d = 8'h00;
      for (n = 0; n < 40 && !ok; n++) begin
         @(negedge clk_in);
         if (rd_valid_in === 1'b1) begin
            ok = 1'b1;
            d = rd_data_in;
         end
      end
   endtask : get

   task automatic wait_idle(output logic [7:0] st);
      logic ok;
      do get(1'b0, st, ok); while (st[7] !== 1'b0 || ok !== 1'b1);
   endtask : wait_idle
endmodule : occ_host_model

// *** testbench/oled_ctrl_command_tail_tb.sv ***
// Self-checking bench for the OLED command tail decoder.
// Assumes occ_ctrl and occ_host_model are compiled before it.
`timescale 1ns/1ps
module oled_ctrl_command_tail_tb
   import occ_pkg::*;
;
   logic clk_in, nrst_in, serial_sel_in;
   logic acc_valid, acc_ready, acc_cds, acc_rd, rd_valid, lay, full, on, rmw;
   logic [7:0] acc_data, rd_data, code, col, st, d;
   logic [3:0] pre, dis;
   logic [2:0] page;
   logic ok;
   int mismatches, cmp_count, cycles;

   occ_ctrl i_dut (.clk_in(clk_in), .nrst_in(nrst_in),
      .acc_valid_in(acc_valid), .acc_ready_out(acc_ready),
      .acc_cds_in(acc_cds), .acc_rd_in(acc_rd), .acc_data_in(acc_data),
      .serial_sel_in(serial_sel_in), .rd_data_out(rd_data),
      .rd_valid_out(rd_valid), .precharge_ticks_out(pre),
      .discharge_ticks_out(dis), .layout_alt_out(lay),
      .deselect_code_out(code), .deselect_full_out(full),
      .display_on_out(on), .rmw_active_out(rmw), .page_out(page),
      .column_out(col));
   occ_host_model i_host (.clk_in(clk_in), .acc_ready_in(acc_ready),
      .rd_valid_in(rd_valid), .rd_data_in(rd_data),
      .acc_valid_out(acc_valid), .acc_cds_out(acc_cds),
      .acc_rd_out(acc_rd), .acc_data_out(acc_data));

   // -----------------------------------------------------------------
   // Clock, timeout and reporting
   // -----------------------------------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   // Ceiling far above the few hundred cycles the scenarios need
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : stop_test
   task automatic check8(input string name, input logic [7:0] exp,
                         input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : check8
   task automatic cmd(input logic [7:0] b);
      i_host.put(1'b0, 1'b0, b);
   endtask : cmd
   task automatic set_col(input logic [7:0] c);
      cmd({4'h1, c[7:4]});
      cmd({4'h0, c[3:0]});
   endtask : set_col

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_reset();
      check8("precharge", 8'h02, {4'h0, pre});
      check8("discharge", 8'h02, {4'h0, dis});
      check8("layout", 8'h01, {7'h00, lay});
      check8("desel_code", 8'h35, code);
      check8("desel_full", 8'h00, {7'h00, full});
      i_host.wait_idle(st);
      check8("status_off", 8'h40, st);
   endtask : t_reset
   task automatic t_period();
      cmd(8'hD9); cmd(8'h5A); i_host.wait_idle(st);
      check8("pre_a", 8'h0A, {4'h0, pre});
      check8("dis_5", 8'h05, {4'h0, dis});
      cmd(8'hD9); cmd(8'h07); i_host.wait_idle(st);
      check8("dis_keep", 8'h05, {4'h0, dis});
      check8("pre_7", 8'h07, {4'h0, pre});
      cmd(8'hD9); cmd(8'hF0); i_host.wait_idle(st);
      check8("dis_f", 8'h0F, {4'h0, dis});
      check8("pre_keep", 8'h07, {4'h0, pre});
   endtask : t_period
   task automatic t_layout();
      cmd(8'hDA); cmd(8'h02); i_host.wait_idle(st);
      check8("layout_seq", 8'h00, {7'h00, lay});
      cmd(8'hDA); cmd(8'h12); i_host.wait_idle(st);
      check8("layout_alt", 8'h01, {7'h00, lay});
   endtask : t_layout
   task automatic t_desel();
      logic [7:0] codes [4] = '{8'h00, 8'h3F, 8'h40, 8'hFF};
      foreach (codes[i]) begin
         cmd(8'hDB); cmd(codes[i]); i_host.wait_idle(st);
         check8("desel_code", codes[i], code);
         check8("desel_full", {7'h00, codes[i] >= 8'h40}, {7'h00, full});
      end
   endtask : t_desel
   task automatic t_display();
      cmd(8'hAF); i_host.wait_idle(st);
      check8("status_on", 8'h00, st);
      check8("display_on", 8'h01, {7'h00, on});
      cmd(8'hAE); i_host.wait_idle(st);
      check8("status_off", 8'h40, st);
   endtask : t_display
   task automatic t_ram();
      cmd(8'hB3); set_col(8'h25);
      i_host.put(1'b1, 1'b0, 8'hA1);
      i_host.put(1'b1, 1'b0, 8'hB2);
      i_host.put(1'b1, 1'b0, 8'hC3);
      i_host.wait_idle(st);
      check8("col_after_wr", 8'h28, col);
      check8("page", 8'h03, {5'h00, page});
      set_col(8'h25);
      i_host.get(1'b1, d, ok);
      i_host.get(1'b1, d, ok);
      check8("rd_first", 8'hA1, d);
      i_host.get(1'b1, d, ok);
      check8("rd_second", 8'hB2, d);
      i_host.wait_idle(st);
      check8("col_after_rd", 8'h27, col);
   endtask : t_ram
   task automatic t_rmw();
      set_col(8'h25); cmd(8'hE0); i_host.wait_idle(st);
      check8("rmw_on", 8'h01, {7'h00, rmw});
      i_host.get(1'b1, d, ok);
      i_host.get(1'b1, d, ok);
      check8("rmw_rd", 8'hA1, d);
      i_host.wait_idle(st);
      check8("rmw_col_rd", 8'h25, col);
      i_host.put(1'b1, 1'b0, 8'h5A);
      i_host.wait_idle(st);
      check8("rmw_col_wr", 8'h26, col);
      cmd(8'hEE); i_host.wait_idle(st);
      check8("rmw_col_back", 8'h25, col);
      check8("rmw_off", 8'h00, {7'h00, rmw});
      i_host.get(1'b1, d, ok);
      i_host.get(1'b1, d, ok);
      check8("rmw_written", 8'h5A, d);
   endtask : t_rmw
   task automatic t_serial();
      @(posedge clk_in);
      serial_sel_in <= 1'b1;
      i_host.get(1'b1, d, ok);
      check8("serial_rd", 8'h00, {7'h00, ok});
      i_host.wait_idle(st);
      check8("serial_status", 8'h40, st);
      @(posedge clk_in);
      serial_sel_in <= 1'b0;
   endtask : t_serial

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      nrst_in = 1'b0;
      serial_sel_in = 1'b0;
      mismatches = 0;
      cmp_count = 0;
      cycles = 0;
      repeat (12) @(posedge clk_in);
      nrst_in <= 1'b1;
      t_reset();
      t_period();
      t_layout();
      t_desel();
      t_display();
      t_ram();
      t_rmw();
      t_serial();
      stop_test();
   end
endmodule : oled_ctrl_command_tail_tb
